// ---- hdl/ntpe_erase_host.v ----
// Host controller for dual-plane block erase of a NAND array
// Functional notes
// R1: Send setup opcode with three row cycles, once or twice.
// R2: Second queued block must lie in the other plane.
// R3: Erase begins only after the confirm opcode is sent.
// R4: Completion seen on ready/busy line or status bit 6.
// R5: Device pulls ready/busy low once erase command is written.
// R6: Device releases ready/busy when internal operation finishes.
// R7: Ready/busy is open drain; host only samples it.
// R8: Device busy during power-up initialisation.
// R9: During initialisation only read-status may be issued.
// R10: Write-protect never asserted while erase is busy.
// R11: Write-protect high from program entry until program finishes.
// R12: Write-protect high from erase entry until erase finishes.
// R13: Status bit 0 set when any targeted block fails.
// R14: Reset opcode aborts a busy operation.
// R15: Confirm under write-protect is ignored, no long busy.
`timescale 1ns/1ps
`include "ntpe_regs.vh"
module ntpe_erase_host #(
	parameter ROW_W = 24
) (
	input  wire             clk_sys,
	input  wire             rst_n,
	input  wire             start,
	input  wire             dual,
	input  wire [ROW_W-1:0] row_a,
	input  wire [ROW_W-1:0] row_b,
	input  wire             abort,
	input  wire             wp_allow,
	output wire             ready,
	output reg              done_q,
	output reg              fail_q,
	output reg              plane_err_q,
	output reg              cle_q,
	output reg              ale_q,
	output reg              we_n_q,
	output reg              re_n_q,
	output reg              wp_n_q,
	output reg  [7:0]       io_out_q,
	output reg              io_oe_q,
	input  wire [7:0]       io_in,
	input  wire             rb_in
);
	localparam S_INIT = 9'h001;
	localparam S_IDLE = 9'h002;
	localparam S_SEND = 9'h004;
	localparam S_WAIT = 9'h008;
	localparam S_BUSY = 9'h010;
	localparam S_STAT = 9'h020;
	localparam S_READ = 9'h040;
	localparam S_RST  = 9'h080;
	localparam S_NEXT = 9'h100;
	// Strobe count is small; the header value is cut to the counter width on purpose
	localparam integer STB_I = `NTPE_STROBE_CYC;
	localparam [3:0]   STB   = STB_I[3:0];
	reg [8:0]       st_q;
	reg [3:0]       cnt_q;
	reg [3:0]       idx_q;
	reg [3:0]       len_q;
	reg             phase_q;
	reg [ROW_W-1:0] ra_q;
	reg [ROW_W-1:0] rb_q;
	reg [8:0]       ret_q;
	// Byte list: setup, 3 rows, [setup, 3 rows], confirm
	function [9:0] seq_byte;
		input [3:0]       i;
		input             d;
		input [ROW_W-1:0] a;
		input [ROW_W-1:0] b;
		reg   [ROW_W-1:0] r;
		reg   [3:0]       j;
		begin
			r = (i < 4'd4) ? a : b;
			j = (i < 4'd4) ? i : i - 4'd4;
			if ((!d && i == 4'd4) || (d && i == 4'd8))
				seq_byte = {2'b10, `NTPE_CMD_ERASE_CONF};
			else if (j == 4'd0)
				seq_byte = {2'b10, `NTPE_CMD_ERASE_SETUP};
			else
				seq_byte = {2'b01, r[(j-1)*8 +: 8]};
		end
	endfunction
	wire [9:0] cur = seq_byte(idx_q, dual, ra_q, rb_q);
	assign ready = (st_q == S_IDLE);
	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= S_INIT; cnt_q <= 4'h0; idx_q <= 4'h0; len_q <= 4'h0;
			phase_q <= 1'b0; ra_q <= {ROW_W{1'b0}}; rb_q <= {ROW_W{1'b0}};
			ret_q <= S_IDLE; done_q <= 1'b0; fail_q <= 1'b0; plane_err_q <= 1'b0;
			cle_q <= 1'b0; ale_q <= 1'b0; we_n_q <= 1'b1; re_n_q <= 1'b1;
			wp_n_q <= 1'b0; io_out_q <= 8'h00; io_oe_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (st_q)
			S_INIT:
			begin
				// Only status polling is legal until the line rises [R8] [R9]
				if (rb_in)
					st_q <= S_IDLE;
			end
			S_IDLE:
			begin
				wp_n_q <= wp_allow;
				if (start)
				begin
					// Two blocks must sit in different planes (low block bit) [R2]
					if (dual && (row_a[6] == row_b[6]))
					begin
						plane_err_q <= 1'b1;
						done_q      <= 1'b1;
					end
					else
					begin
						plane_err_q <= 1'b0;
						ra_q <= row_a; rb_q <= row_b;
						idx_q <= 4'h0;
						len_q <= dual ? 4'd9 : 4'd5; // [R1]
						wp_n_q <= wp_allow; // [R12]
						ret_q <= S_WAIT; cnt_q <= 4'h0; phase_q <= 1'b0;
						st_q <= S_SEND;
					end
				end
			end
			S_SEND:
			begin
				// Each byte: low strobe then high strobe
				io_oe_q <= 1'b1;
				cle_q <= cur[9]; ale_q <= cur[8]; io_out_q <= cur[7:0];
				we_n_q <= phase_q;
				if (cnt_q == STB - 4'd1)
				begin
					cnt_q <= 4'h0;
					phase_q <= ~phase_q;
					if (phase_q)
					begin
						if (idx_q == len_q - 4'd1)
						begin
							io_oe_q <= 1'b0; cle_q <= 1'b0; ale_q <= 1'b0;
							st_q <= ret_q;
						end
						else
							idx_q <= idx_q + 4'd1; // Confirm is last [R3]
					end
				end
				else
					cnt_q <= cnt_q + 4'd1;
			end
			S_WAIT:
			begin
				// Skip the busy wait when protected; device ignores it [R15]
				if (!wp_n_q)
				begin
					fail_q <= 1'b1;
					done_q <= 1'b1;
					st_q   <= S_IDLE;
				end
				else if (!rb_in)
					st_q <= S_BUSY; // [R5]
			end
			S_BUSY:
			begin
				// Write-protect is frozen here [R10] [R12]
				if (abort)
				begin
					ra_q <= {{(ROW_W-8){1'b0}}, `NTPE_CMD_RESET}; // [R14]
					idx_q <= 4'h0; len_q <= 4'd1; ret_q <= S_RST;
					cnt_q <= 4'h0; phase_q <= 1'b0; st_q <= S_NEXT;
				end
				else if (rb_in)
				begin
					// Line released, now read status [R4] [R6] [R7]
					ra_q <= {{(ROW_W-8){1'b0}}, `NTPE_CMD_READ_STATUS};
					idx_q <= 4'h0; len_q <= 4'd1; ret_q <= S_STAT;
					cnt_q <= 4'h0; phase_q <= 1'b0; st_q <= S_NEXT;
				end
			end
			S_NEXT:
			begin
				// Single command byte from ra_q low bits
				io_oe_q <= 1'b1; cle_q <= 1'b1; io_out_q <= ra_q[7:0];
				we_n_q <= phase_q;
				if (cnt_q == STB - 4'd1)
				begin
					cnt_q <= 4'h0;
					phase_q <= ~phase_q;
					if (phase_q)
					begin
						io_oe_q <= 1'b0; cle_q <= 1'b0;
						st_q <= ret_q;
					end
				end
				else
					cnt_q <= cnt_q + 4'd1;
			end
			S_STAT:
			begin
				re_n_q <= 1'b0;
				if (cnt_q == STB - 4'd1)
				begin
					cnt_q <= 4'h0;
					st_q <= S_READ;
				end
				else
					cnt_q <= cnt_q + 4'd1;
			end
			S_READ:
			begin
				// Sample before the read strobe rises
				re_n_q <= 1'b1;
				// A status still showing busy counts as a failure
				fail_q <= io_in[`NTPE_SR_FAIL] | ~io_in[`NTPE_SR_READY]; // [R4] [R13]
				done_q <= 1'b1;
				st_q   <= S_IDLE;
			end
			S_RST:
			begin
				// Abort leaves blocks undefined; report failure
				if (rb_in)
				begin
					fail_q <= 1'b1;
					done_q <= 1'b1;
					st_q   <= S_IDLE;
				end
			end
			default:
				st_q <= S_INIT;
			endcase
		end
	end
endmodule // ntpe_erase_host

// ---- hdl/ntpe_regs.vh ----
// Opcodes, status bits and strobe timing for the NAND erase host
`ifndef NTPE_REGS_VH
`define NTPE_REGS_VH
`define NTPE_CMD_ERASE_SETUP 8'h60
`define NTPE_CMD_ERASE_CONF  8'hd0
`define NTPE_CMD_READ_STATUS 8'h70
`define NTPE_CMD_RESET       8'hff
`define NTPE_SR_FAIL         0
`define NTPE_SR_READY        6
`define NTPE_CLK_NS          10
`define NTPE_STROBE_NS       25
`define NTPE_STROBE_CYC      ((`NTPE_STROBE_NS + `NTPE_CLK_NS - 1) / `NTPE_CLK_NS)
`define NTPE_ROW_CYCLES      3
`endif

// ---- tb/ntpe_dev_model.sv ----
// Behavioural NAND array for erase
`timescale 1ns/1ps
module ntpe_dev_model (
	input wire cle, ale, we_n, re_n, wp_n, bad,
	input wire [7:0] io,
	output wire [7:0] io_in,
	output wire rb_in
);
	time rel = 700; // Power-up busy
	reg busy = 1, fail_q = 0;
	integer nset = 0, nq = 0;
	reg [23:0] rowq = 24'h000000; // Last row latched, low byte first
	wire [7:0] sr = {wp_n, !busy, 5'h0, fail_q};
	always #1 busy = $time < rel;
	assign rb_in = busy ? 1'b0 : 1'b1; // Pull-up when released
	assign io_in = re_n ? ~sr : sr; // Idle bus never echoes
	always @(posedge we_n)
	begin
		if (ale)
			rowq = {io, rowq[23:8]};
		if (cle && io == 8'h60 && !busy) // Only status during init
			nset = nset + 1;
		if (cle && io == 8'hd0)
		begin
			nq = nset;
			nset = 0;
			if (wp_n && !busy)
			begin
				rel = $time + 400; // Busy follows within 1 ns
				fail_q = bad; // Any failing block
			end
		end
		if (cle && io == 8'hff && busy)
		begin
			rel = $time + 50;
			fail_q = 1;
		end
	end
endmodule // ntpe_dev_model

// ---- tb/ntpe_erase_host_monitor.sv ----
// Pin checks for the erase host
`timescale 1ns/1ps
module ntpe_erase_host_monitor (
	input wire clk_sys, rst_n, ready, done_q, plane_err_q,
	input wire cle_q, ale_q, we_n_q, wp_n_q, io_oe_q, rb_in,
	input wire [7:0] io_out_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_stb; $fell(we_n_q) |=> !we_n_q ##1 !we_n_q ##1 we_n_q; endproperty
	a_stb: assert property (p_stb) else $error("strobe width");
	property p_hold; !we_n_q && $past(!we_n_q) |-> $stable(io_out_q) && $stable(cle_q); endproperty
	a_hold: assert property (p_hold) else $error("byte moved");
	property p_excl; !(cle_q && ale_q); endproperty
	a_excl: assert property (p_excl) else $error("cle with ale");
	property p_plane; $rose(plane_err_q) |-> done_q; endproperty
	a_plane: assert property (p_plane) else $error("plane flag");
	property p_oe; !we_n_q |-> io_oe_q; endproperty
	a_oe: assert property (p_oe) else $error("bus not driven");
	property p_done; done_q |=> !done_q; endproperty
	a_done: assert property (p_done) else $error("done width");
	property p_init; $rose(ready) |-> rb_in; endproperty
	a_init: assert property (p_init) else $error("ready while busy");
	property p_busy; $fell(we_n_q) && !rb_in |-> io_out_q == 8'h70 || io_out_q == 8'hff;
	endproperty
	a_busy: assert property (p_busy) else $error("write while busy");
	property p_wp; $changed(wp_n_q) |-> $past(ready); endproperty
	a_wp: assert property (p_wp) else $error("wp moved");
	c_clash: cover property (done_q && plane_err_q);
	c_busy: cover property ($fell(rb_in) ##[1:100] $rose(rb_in));
	c_prot: cover property (done_q && !wp_n_q);
endmodule // ntpe_erase_host_monitor
bind ntpe_erase_host ntpe_erase_host_monitor ntpe_erase_host_monitor_i (
	.clk_sys     (clk_sys),
	.rst_n       (rst_n),
	.ready       (ready),
	.done_q      (done_q),
	.plane_err_q (plane_err_q),
	.cle_q       (cle_q),
	.ale_q       (ale_q),
	.we_n_q      (we_n_q),
	.wp_n_q      (wp_n_q),
	.io_oe_q     (io_oe_q),
	.rb_in       (rb_in),
	.io_out_q    (io_out_q)
);

// ---- tb/ntpe_erase_host_tb.sv ----
// Random and corner erase runs
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module ntpe_erase_host_tb;
	reg clk_sys = 0, rst_n = 0, start = 0, dual = 0, abort = 0, wp_allow = 1, bad = 0;
	reg [23:0] row_a = 0, row_b = 0;
	wire ready, done_q, fail_q, plane_err_q, cle_q, ale_q, we_n_q, re_n_q, wp_n_q;
	wire io_oe_q, rb_in;
	wire [7:0] io_out_q, io_in;
	integer bad_count = 0, comparisons = 0, i, k;
	always #5 clk_sys = ~clk_sys;
	ntpe_erase_host ntpe_erase_host_i (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.start       (start),
		.dual        (dual),
		.row_a       (row_a),
		.row_b       (row_b),
		.abort       (abort),
		.wp_allow    (wp_allow),
		.ready       (ready),
		.done_q      (done_q),
		.fail_q      (fail_q),
		.plane_err_q (plane_err_q),
		.cle_q       (cle_q),
		.ale_q       (ale_q),
		.we_n_q      (we_n_q),
		.re_n_q      (re_n_q),
		.wp_n_q      (wp_n_q),
		.io_out_q    (io_out_q),
		.io_oe_q     (io_oe_q),
		.io_in       (io_in),
		.rb_in       (rb_in)
	);
	ntpe_dev_model ntpe_dev_model_i (.cle(cle_q), .ale(ale_q), .we_n(we_n_q), .re_n(re_n_q),
		.wp_n(wp_n_q), .bad(bad), .io(io_out_q), .io_in(io_in), .rb_in(rb_in));
	// Plane is the block address low bit, row bit 6
	function automatic logic exp_clash(input d, input [23:0] a, input [23:0] b);
		return d && (a[6] == b[6]);
	endfunction
	function automatic logic exp_fail(input w, input f, input ab);
		return !w || f || ab;
	endfunction
	task final_report;
	begin
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	task wait_for(input integer w);
	begin
		for (k = 0; k < 5000 && (w ? done_q : ready) !== 1'b1; k++)
			@(posedge clk_sys) #1;
		if (k == 5000)
		begin
			bad_count++;
			final_report;
		end
	end
	endtask
	task run(input d, w, f, ab, input [23:0] a, b);
		reg pe;
	begin
		wait_for(0);
		{dual, wp_allow, bad, abort, row_a, row_b} = {d, w, f, ab, a, b};
		start = 1;
		@(posedge clk_sys) #1 start = 0;
		wait_for(1);
		pe = exp_clash(d, a, b);
		`CHK("plane_err", pe, plane_err_q)
		if (!pe)
		begin
			`CHK("fail", exp_fail(w, f, ab), fail_q)
			`CHK("setups", d ? 2 : 1, ntpe_dev_model_i.nq)
			`CHK("last_row", d ? b : a, ntpe_dev_model_i.rowq)
		end
		$display("test d%0d w%0d f%0d a%0d ended", d, w, f, ab);
		@(posedge clk_sys) #1 abort = 0;
	end
	endtask
	initial
	begin
		k = $urandom(50625);
		repeat (20) @(posedge clk_sys);
		#1 rst_n = 1;
		run(1, 1, 0, 0, 24'h000040, 24'h000080);
		run(1, 1, 0, 0, 24'h000040, 24'h0000c0);
		run(0, 0, 0, 0, 24'h000100, 24'h000000); // Protected, held low
		run(1, 1, 0, 1, 24'h000000, 24'h000040);
		run(1, 1, 1, 0, 24'h000000, 24'h000040);
		for (i = 0; i < 12; i++)
			run($urandom % 2, $urandom % 4 != 0, $urandom % 2, $urandom % 5 == 0,
				$urandom, $urandom);
		final_report;
	end
endmodule // ntpe_erase_host_tb
